// >>> include/ssp_pkg.sv
// Constants, register map and types for the synchronous serial audio port.
// Shared by the port core, the compander interface and the compander.
package ssp_pkg;

  // Clock and bit rate limit.
  localparam int CLK_KHZ      = 50000;
  localparam int MAX_BIT_KBPS = 56250;
  localparam int HALF_MIN_CLK = (CLK_KHZ + 2 * MAX_BIT_KBPS - 1) / (2 * MAX_BIT_KBPS);

  // Widths.
  localparam int NLINES   = 2;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int CTRL_W   = 14;
  localparam int CLKDIV_W = 16;
  localparam int FRAME_W  = 12;
  localparam int SLOT_W   = 7;
  localparam int WL_W     = 5;
  localparam int BITS_W   = 6;
  localparam int MODE_W   = 3;
  localparam int LAW_W    = 2;
  localparam int LIN_W    = 16;
  localparam int CODE_W   = 8;
  localparam int STAT_W   = 3;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CLKDIV  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FRAME   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COMPAND = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STAT    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_MASK    = 8'h14;
  localparam logic [ADDR_W-1:0] REG_DATA0   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_DATA1   = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_STATE   = 8'h20;

  // Field positions.
  localparam int CTRL_EN       = 0;
  localparam int CTRL_MODE     = 1;
  localparam int CTRL_WL       = 4;
  localparam int CTRL_MSB      = 9;
  localparam int CTRL_SCLK_INT = 10;
  localparam int CTRL_FS_INT   = 11;
  localparam int CTRL_DIR      = 12;
  localparam int FRAME_LEN     = 0;
  localparam int FRAME_SLOTS   = 16;
  localparam int STAT_FS_ERR   = 0;
  localparam int STAT_WORD0    = 1;
  localparam int STATE_ACTIVE  = 0;
  localparam int STATE_SLOT    = 8;

  // Reset values.
  localparam logic [STAT_W-1:0] MASK_RST = 3'h1;

  // Word length limits, coded as length minus one.
  localparam logic [WL_W-1:0] WL_MIN        = 5'h02;
  localparam logic [WL_W-1:0] WL_MIN_STEREO = 5'h07;

  // Falling edges from a sync edge to the first bit.
  localparam logic [1:0] LAG_ONE = 2'h1;
  localparam logic [1:0] LAG_I2S = 2'h2;

  // Compander constants.
  localparam logic [LIN_W-1:0]  MU_BIAS      = 16'h0084;
  localparam logic [LIN_W-1:0]  MU_CLIP      = 16'h7F7B;
  localparam int                MU_SEG_LSB   = 7;
  localparam int                MU_MAN_SHIFT = 3;
  localparam logic [CODE_W-1:0] A_XOR        = 8'h55;
  localparam logic [LIN_W-1:0]  A_CLIP       = 16'h0FFF;
  localparam logic [LIN_W-1:0]  A_HALF       = 16'h0008;
  localparam logic [LIN_W-1:0]  A_SEG_STEP   = 16'h0100;
  localparam int                A_PRE_SHIFT  = 3;
  localparam int                A_SEG_LSB    = 5;

  typedef enum logic [MODE_W-1:0] {
    MODE_STD, MODE_TDM, MODE_I2S, MODE_PI2S, MODE_LJ
  } ssp_mode_t;

  typedef enum logic [LAW_W-1:0] {LAW_NONE, LAW_MU, LAW_A} ssp_law_t;

endpackage

// >>> include/ssp_cmp_if.sv
// Interface between the port core and one line's compander.
// The core supplies law and samples; the compander answers combinationally.
`timescale 1ns/1ps
`default_nettype none

interface ssp_cmp_if
  import ssp_pkg::*;
();
  ssp_law_t          law;
  logic [LIN_W-1:0]  lin_in;
  logic [CODE_W-1:0] code_out;
  logic [CODE_W-1:0] code_in;
  logic [LIN_W-1:0]  lin_out;

  modport core (output law, lin_in, code_in, input code_out, lin_out);
  modport cmp  (input law, lin_in, code_in, output code_out, lin_out);
endinterface

`default_nettype wire

// >>> verilog/ssp_compand.sv
// Mu-law and A-law compressor and expander for one data line.
// Purely combinational; the core registers everything around it.
`timescale 1ns/1ps
`default_nettype none

module ssp_compand
  import ssp_pkg::*;
(
  // Samples and codes of one line.
  ssp_cmp_if.cmp port
);

  logic              sgn;
  logic [LIN_W-1:0]  mag;
  logic [2:0]        seg;
  logic [3:0]        man;
  logic [LIN_W-1:0]  t;
  logic [CODE_W-1:0] c;

  // Compression of a 16-bit linear sample into an 8-bit code.
  always_comb begin
    sgn = port.lin_in[LIN_W-1];
    mag = sgn ? LIN_W'(-port.lin_in) : port.lin_in;
    seg = '0;
    man = '0;
    port.code_out = '0;
    case (port.law)
      LAW_MU: begin
        if (mag > MU_CLIP) begin
          mag = MU_CLIP;
        end
        mag = mag + MU_BIAS;
        for (int i = 0; i < 8; i++) begin
          if (mag[MU_SEG_LSB + i]) begin
            seg = 3'(i);
          end
        end
        man = 4'(mag >> (seg + MU_MAN_SHIFT));
        port.code_out = ~{sgn, seg, man};
      end
      LAW_A: begin
        mag = mag >> A_PRE_SHIFT;
        if (mag > A_CLIP) begin
          mag = A_CLIP;
        end
        for (int i = 0; i < 7; i++) begin
          if (mag[A_SEG_LSB + i]) begin
            seg = 3'(i + 1);
          end
        end
        man = (seg == 3'h0) ? 4'(mag >> 1) : 4'(mag >> seg);
        port.code_out = {~sgn, seg, man} ^ A_XOR;
      end
      default: ;
    endcase
  end

  // Expansion of an 8-bit code back to a 16-bit linear sample.
  always_comb begin
    c = '0;
    t = '0;
    port.lin_out = '0;
    case (port.law)
      LAW_MU: begin
        c = ~port.code_in;
        t = LIN_W'((LIN_W'({c[3:0], 3'h0}) + MU_BIAS) << c[6:4]);
        port.lin_out = c[7] ? LIN_W'(MU_BIAS - t) : LIN_W'(t - MU_BIAS);
      end
      LAW_A: begin
        c = port.code_in ^ A_XOR;
        t = LIN_W'({c[3:0], 4'h0}) + A_HALF;
        if (c[6:4] != 3'h0) begin
          t = t + A_SEG_STEP;
        end
        if (c[6:4] > 3'h1) begin
          t = LIN_W'(t << (c[6:4] - 3'h1));
        end
        port.lin_out = c[7] ? t : LIN_W'(-t);
      end
      default: ;
    endcase
  end

endmodule // ssp_compand

`default_nettype wire

// >>> verilog/ssp_sync_serial_port.sv
// One synchronous serial audio port: register slave, link timing, two data lines.
// Assumes one 50 MHz clock; link pins come from outside it and are resynchronised.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ssp_sync_serial_port
  import ssp_pkg::*;
(
  // Clock and reset.
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // Register port.
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // Serial clock pin.
  input  wire logic              i_sclk,
  output logic                   o_sclk,
  output logic                   o_sclk_oe,
  // Frame sync pin.
  input  wire logic              i_fs,
  output logic                   o_fs,
  output logic                   o_fs_oe,
  // Data pins.
  input  wire logic [NLINES-1:0] i_data,
  output logic      [NLINES-1:0] o_data,
  output logic      [NLINES-1:0] o_data_oe,
  // DMA requests, one per line.
  output logic      [NLINES-1:0] o_dma_req,
  // Shared error interrupt.
  input  wire logic              i_peer_err,
  output logic                   o_err_irq
);

  // Registers.
  logic [CTRL_W-1:0]   ctrl;
  logic [CLKDIV_W-1:0] clkdiv;
  logic [FRAME_W-1:0]  frame_last;
  logic [SLOT_W-1:0]   slot_last;
  logic [NLINES*LAW_W-1:0] cmp_cfg;
  logic [STAT_W-1:0]   stat;
  logic [STAT_W-1:0]   mask;
  logic [DATA_W-1:0]   tx_hold [NLINES];
  logic [DATA_W-1:0]   rx_hold [NLINES];

  // Decoded controls.
  logic                en;
  logic                msb_first;
  logic                sclk_int;
  logic                fs_int;
  ssp_mode_t           mode;
  logic                stereo;
  logic                paired;
  logic [WL_W-1:0]     wl_cfg;
  logic [WL_W-1:0]     wl;
  logic [WL_W-1:0]     wl_min;
  logic [NLINES-1:0]   dir;

  assign en        = ctrl[CTRL_EN];
  assign msb_first = ctrl[CTRL_MSB];
  assign sclk_int  = ctrl[CTRL_SCLK_INT];
  assign fs_int    = ctrl[CTRL_FS_INT];
  assign mode      = ssp_mode_t'(ctrl[CTRL_MODE +: MODE_W]);
  assign stereo    = (mode == MODE_I2S) || (mode == MODE_PI2S) || (mode == MODE_LJ);
  assign paired    = (mode == MODE_TDM) || (mode == MODE_PI2S);
  assign wl_cfg    = ctrl[CTRL_WL +: WL_W];

  // Short words are raised to the floor of the mode instead of misbehaving.
  assign wl_min = stereo ? WL_MIN_STEREO : WL_MIN;
  assign wl     = (wl_cfg < wl_min) ? wl_min : wl_cfg;

  // A TDM port is a pure transmitter or pure receiver; line 0 decides.
  assign dir = (mode == MODE_TDM) ? {NLINES{ctrl[CTRL_DIR]}}
                                  : ctrl[CTRL_DIR +: NLINES];

  // Pin synchronisers.
  logic              sclk_m;
  logic              sclk_s;
  logic              sclk_d;
  logic              fs_m;
  logic              fs_s;
  logic [NLINES-1:0] din_m;
  logic [NLINES-1:0] din_s;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      fs_m   <= 1'b0;
      fs_s   <= 1'b0;
      din_m  <= '0;
      din_s  <= '0;
    end else begin
      sclk_m <= i_sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      fs_m   <= i_fs;
      fs_s   <= fs_m;
      din_m  <= i_data;
      din_s  <= din_m;
    end
  end

  // Internal serial clock; the floor on the half period caps the bit rate.
  localparam logic [CLKDIV_W-1:0] HALF_MIN = CLKDIV_W'(HALF_MIN_CLK - 1);

  logic [CLKDIV_W-1:0] half_cnt;
  logic [CLKDIV_W-1:0] div_cnt;
  logic                sclk_gen;

  assign half_cnt = (clkdiv < HALF_MIN) ? HALF_MIN : clkdiv;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      div_cnt  <= '0;
      sclk_gen <= 1'b0;
    end else if (!en || !sclk_int) begin
      div_cnt  <= '0;
      sclk_gen <= 1'b0;
    end else if (div_cnt == half_cnt) begin
      div_cnt  <= '0;
      sclk_gen <= ~sclk_gen;
    end else begin
      div_cnt  <= div_cnt + 1'b1;
    end
  end

  // Serial clock edges, from the divider or from the synchronised pin.
  logic tick;
  logic ev_rise;
  logic ev_fall;

  assign tick    = sclk_int ? (div_cnt == half_cnt) : (sclk_s != sclk_d);
  assign ev_rise = en && tick && (sclk_int ? !sclk_gen : sclk_s);
  assign ev_fall = en && tick && (sclk_int ? sclk_gen : !sclk_s);

  // Internal frame sync, advanced on falling edges.
  logic [FRAME_W-1:0] fpos;
  logic [FRAME_W-1:0] next_fpos;
  logic [FRAME_W-1:0] half;
  logic               fs_gen;

  assign next_fpos = (fpos == frame_last) ? '0 : fpos + 1'b1;
  assign half      = frame_last[FRAME_W-1:1] + FRAME_W'(frame_last[0]);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fpos   <= '0;
      fs_gen <= 1'b0;
    end else if (!en || !fs_int) begin
      fpos   <= '0;
      fs_gen <= 1'b0;
    end else if (ev_fall) begin
      fpos <= next_fpos;
      case (mode)
        MODE_I2S, MODE_PI2S: fs_gen <= (next_fpos >= half);
        MODE_LJ:             fs_gen <= (next_fpos < half);
        default:             fs_gen <= (next_fpos == '0);
      endcase
    end
  end

  // Frame sync edges: any edge in stereo modes, a rising one otherwise.
  logic fs_now;
  logic fs_prev;
  logic fs_edge;

  assign fs_now  = fs_int ? fs_gen : fs_s;
  assign fs_edge = stereo ? (fs_now != fs_prev) : (fs_now && !fs_prev);

  // Word sequencing shared by both lines.
  logic [1:0]        lag;
  logic              active;
  logic [BITS_W-1:0] left;
  logic [SLOT_W-1:0] slot;
  logic              more;
  logic              load;
  logic              err_ev;
  logic [BITS_W-1:0] idx_dn;
  logic [BITS_W-1:0] idx_up;
  logic [WL_W-1:0]   idx;

  // Packed modes carry further slots back to back after the first.
  assign more = paired && (slot != slot_last);
  assign load = ev_fall && ((lag == LAG_ONE) || (active && left == '0 && more));

  // A sync edge before the last bit of the word is an early frame sync.
  assign err_ev = ev_rise && fs_edge && active && (left > BITS_W'(1));

  assign idx_dn = left - 1'b1;
  assign idx_up = {1'b0, wl} + 1'b1 - left;
  assign idx    = msb_first ? idx_dn[WL_W-1:0] : idx_up[WL_W-1:0];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fs_prev <= 1'b0;
      lag     <= '0;
      active  <= 1'b0;
      left    <= '0;
      slot    <= '0;
    end else if (!en) begin
      fs_prev <= 1'b0;
      lag     <= '0;
      active  <= 1'b0;
      left    <= '0;
      slot    <= '0;
    end else begin
      if (ev_rise) begin
        fs_prev <= fs_now;
      end
      // I2S waits one more bit before the first data bit.
      if (ev_rise && fs_edge) begin
        lag <= (mode == MODE_I2S) ? LAG_I2S : LAG_ONE;
      end else if (ev_fall && lag != '0) begin
        lag <= lag - 1'b1;
      end
      if (load) begin
        active <= 1'b1;
        left   <= {1'b0, wl} + 1'b1;
        slot   <= (lag == LAG_ONE) ? '0 : slot + 1'b1;
      end else if (ev_fall && active && left == '0) begin
        active <= 1'b0;
      end else if (ev_rise && active && left != '0) begin
        left <= left - 1'b1;
      end
    end
  end

  // Compander per line.
  logic [CODE_W-1:0] tx_code [NLINES];
  logic [LIN_W-1:0]  rx_lin  [NLINES];
  ssp_law_t          law     [NLINES];
  logic [DATA_W-1:0] tx_sel  [NLINES];
  logic [DATA_W-1:0] tx_word [NLINES];
  logic [DATA_W-1:0] rx_sh   [NLINES];

  for (genvar g = 0; g < NLINES; g++) begin : g_line
    ssp_cmp_if cif ();

    assign cif.law     = ssp_law_t'(cmp_cfg[g*LAW_W +: LAW_W]);
    assign cif.lin_in  = tx_hold[g][LIN_W-1:0];
    assign cif.code_in = rx_sh[g][CODE_W-1:0];
    assign tx_code[g]  = cif.code_out;
    assign rx_lin[g]   = cif.lin_out;
    assign law[g]      = cif.law;
    assign tx_sel[g]   = (cif.law != LAW_NONE)
                       ? {{(DATA_W-CODE_W){1'b0}}, tx_code[g]} : tx_hold[g];

    ssp_compand u_cmp (
      .port (cif.cmp)
    );
  end

  // Both lines shift in step, which gives four stereo channels per port.
  logic [NLINES-1:0] dout;
  logic [NLINES-1:0] rx_done;
  logic [NLINES-1:0] dma_ev;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dout    <= '0;
      rx_done <= '0;
      for (int l = 0; l < NLINES; l++) begin
        tx_word[l] <= '0;
        rx_sh[l]   <= '0;
      end
    end else begin
      for (int l = 0; l < NLINES; l++) begin
        rx_done[l] <= 1'b0;
        if (load) begin
          tx_word[l] <= tx_sel[l];
          rx_sh[l]   <= '0;
          dout[l]    <= tx_sel[l][msb_first ? wl : '0];
        end else if (ev_fall && active && left != '0) begin
          dout[l] <= tx_word[l][idx];
        end
        if (ev_rise && active && left != '0) begin
          rx_sh[l][idx] <= din_s[l];
          rx_done[l]    <= (left == BITS_W'(1)) && !dir[l];
        end
      end
    end
  end

  // A transmitter asks for a refill on load, a receiver on a full word.
  always_comb begin
    for (int l = 0; l < NLINES; l++) begin
      dma_ev[l] = dir[l] ? load : rx_done[l];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_dma_req <= '0;
      for (int l = 0; l < NLINES; l++) begin
        rx_hold[l] <= '0;
      end
    end else begin
      o_dma_req <= dma_ev;
      for (int l = 0; l < NLINES; l++) begin
        if (rx_done[l]) begin
          rx_hold[l] <= (law[l] != LAW_NONE)
                      ? {{(DATA_W-LIN_W){rx_lin[l][LIN_W-1]}}, rx_lin[l]} : rx_sh[l];
        end
      end
    end
  end

  // Register writes.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl       <= '0;
      clkdiv     <= '0;
      frame_last <= '0;
      slot_last  <= '0;
      cmp_cfg    <= '0;
      mask       <= MASK_RST;
      for (int l = 0; l < NLINES; l++) begin
        tx_hold[l] <= '0;
      end
    end else if (i_wr) begin
      case (i_addr)
        REG_CTRL:    ctrl    <= i_wdata[CTRL_W-1:0];
        REG_CLKDIV:  clkdiv  <= i_wdata[CLKDIV_W-1:0];
        REG_FRAME: begin
          frame_last <= i_wdata[FRAME_LEN +: FRAME_W];
          slot_last  <= i_wdata[FRAME_SLOTS +: SLOT_W];
        end
        REG_COMPAND: cmp_cfg <= i_wdata[NLINES*LAW_W-1:0];
        REG_MASK:    mask    <= i_wdata[STAT_W-1:0];
        REG_DATA0:   tx_hold[0] <= i_wdata;
        REG_DATA1:   tx_hold[1] <= i_wdata;
        default: ;
      endcase
    end
  end

  // Sticky status; a new event in the clearing read's cycle survives.
  logic [STAT_W-1:0] stat_ev;

  always_comb begin
    stat_ev              = '0;
    stat_ev[STAT_FS_ERR] = err_ev;
    for (int l = 0; l < NLINES; l++) begin
      stat_ev[STAT_WORD0 + l] = dma_ev[l];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stat <= '0;
    end else begin
      stat <= ((i_rd && i_addr == REG_STAT) ? '0 : stat) | stat_ev;
    end
  end

  // Register reads; data stands only in the cycle after the strobe.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL:    o_rdata <= DATA_W'(ctrl);
        REG_CLKDIV:  o_rdata <= DATA_W'(clkdiv);
        REG_FRAME:   o_rdata <= (DATA_W'(slot_last) << FRAME_SLOTS)
                              | (DATA_W'(frame_last) << FRAME_LEN);
        REG_COMPAND: o_rdata <= DATA_W'(cmp_cfg);
        REG_STAT:    o_rdata <= DATA_W'(stat);
        REG_MASK:    o_rdata <= DATA_W'(mask);
        REG_DATA0:   o_rdata <= rx_hold[0];
        REG_DATA1:   o_rdata <= rx_hold[1];
        REG_STATE:   o_rdata <= (DATA_W'(slot) << STATE_SLOT)
                              | (DATA_W'(active) << STATE_ACTIVE);
        default:     o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // Other ports' errors arrive already combined on the peer input.
  assign o_err_irq = (|(stat & mask)) || i_peer_err;

  // Pin drivers.
  assign o_sclk    = sclk_gen;
  assign o_sclk_oe = en && sclk_int;
  assign o_fs      = fs_gen;
  assign o_fs_oe   = en && fs_int;
  assign o_data    = dout;
  assign o_data_oe = en ? dir : '0;

endmodule // ssp_sync_serial_port

`default_nettype wire

// >>> testbench/ssp_checker_assertions.sv
// Checker for the serial audio port, watching only the top-level ports.
// Assumes one clock domain; it shadows CTRL, MASK and CLKDIV from bus writes.
`timescale 1ns/1ps
`default_nettype none
module ssp_checker
  import ssp_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_sclk,
  input wire logic              o_sclk_oe,
  input wire logic              o_fs,
  input wire logic              o_fs_oe,
  input wire logic [NLINES-1:0] o_data_oe,
  input wire logic [NLINES-1:0] o_dma_req,
  input wire logic              i_peer_err,
  input wire logic              o_err_irq
);
  logic [CTRL_W-1:0]   ctl;
  logic [STAT_W-1:0]   msk;
  logic [CLKDIV_W-1:0] div;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctl <= '0;
      msk <= MASK_RST;
      div <= '0;
    end else if (i_wr) begin
      if (i_addr == REG_CTRL) ctl <= i_wdata[CTRL_W-1:0];
      if (i_addr == REG_MASK) msk <= i_wdata[STAT_W-1:0];
      if (i_addr == REG_CLKDIV) div <= i_wdata[CLKDIV_W-1:0];
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data off cycle");
  property p_rd_hole; i_rd && i_addr == 8'h40 |=> o_rdata == '0; endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("hole read not zero");
  property p_sclk_oe; o_sclk_oe == (ctl[CTRL_EN] && ctl[CTRL_SCLK_INT]); endproperty
  a_sclk_oe: assert property (p_sclk_oe) else $error("clock enable wrong");
  property p_fs_oe; o_fs_oe == (ctl[CTRL_EN] && ctl[CTRL_FS_INT]); endproperty
  a_fs_oe: assert property (p_fs_oe) else $error("sync enable wrong");
  property p_data_oe;
    ctl[CTRL_MODE +: MODE_W] != MODE_TDM |->
      o_data_oe == (ctl[CTRL_EN] ? ctl[CTRL_DIR +: NLINES] : 2'h0);
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("line direction wrong");
  property p_dma_pulse; (o_dma_req & $past(o_dma_req)) == '0; endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("request too long");
  property p_peer; i_peer_err |-> o_err_irq; endproperty
  a_peer: assert property (p_peer) else $error("peer error lost");
  // Only a status read or a register write may lower an interrupt raised by this port.
  property p_irq_sticky;
    o_err_irq && !i_peer_err && !i_wr && !(i_rd && i_addr == REG_STAT) |=> o_err_irq;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped");
  property p_sclk_gen;
    o_sclk_oe && div == '0 && $rose(o_sclk) |=> !o_sclk || !o_sclk_oe;
  endproperty
  a_sclk_gen: assert property (p_sclk_gen) else $error("clock half period wrong");
  property p_fs_step; o_fs_oe && o_sclk_oe && $changed(o_fs) |-> $fell(o_sclk); endproperty
  a_fs_step: assert property (p_fs_step) else $error("sync moved off a clock fall");
  c_peer: cover property (i_peer_err && o_err_irq);
  c_sclk: cover property (o_sclk_oe && $rose(o_sclk));
  c_clear: cover property ($fell(o_err_irq));
endmodule // ssp_checker
`default_nettype wire

// >>> testbench/ssp_codec_model.sv
// Behavioural codec on the far side: makes link clock and sync, sends and takes words.
// Assumes sample pairs of 8 bits, most significant first, one bit after each sync edge.
`timescale 1ns/1ps
`default_nettype none
module ssp_codec_model (
  // Link pins.
  output logic            o_sclk,
  output logic            o_fs,
  output logic      [1:0] o_data,
  input  wire logic [1:0] i_data,
  // Words taken from the device.
  output logic      [7:0] o_word,
  output int              o_cnt
);
  int         k;
  logic [7:0] sh;
  logic [7:0] w;
  initial begin
    k = 0;
    o_sclk = 1'b0;
    o_fs = 1'b0;
    o_data = 2'h0;
    o_word = 8'h00;
    o_cnt = 0;
  end
  function automatic logic [7:0] pat(input int n);
    return 8'(n * 8'h35 + 8'h1B);
  endfunction
  // The clock runs only inside these calls; an early sync is an extra edge mid word.
  task automatic frames(input int n, input bit early);
    for (int h = 0; h < 2 * n; h++) begin
      w = pat(k);
      for (int b = 0; b < 10; b++) begin
        o_sclk = 1'b0;
        // An early run toggles here so that every half opens with an edge.
        if (b == 0) o_fs = early ? ~o_fs : (h % 2 == 0);
        if (early && b == 4) o_fs = ~o_fs;
        if (b >= 2) sh = {sh[6:0], i_data[0]};
        if (b == 9) begin
          o_word = sh;
          o_cnt++;
        end
        // A released line shows the inverse of its last bit, never a held value.
        o_data[1] = (b >= 1 && b <= 8) ? w[8-b] : ~o_data[1];
        o_data[0] = ~o_data[0];
        #80 o_sclk = 1'b1;
        #80;
      end
      k++;
    end
  endtask
endmodule // ssp_codec_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench: bus tasks, a codec model on the link, queued expectations.
// Assumes the checker module is compiled beforehand and bound below.
`timescale 1ns/1ps
`default_nettype none
module tb
  import ssp_pkg::*;
;
  logic              i_clock, i_rst, i_wr, i_rd, i_peer_err;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  wire  [DATA_W-1:0] o_rdata;
  wire               o_sclk, o_sclk_oe, o_fs, o_fs_oe, o_err_irq, sclk, fs;
  wire  [NLINES-1:0] o_data, o_data_oe, o_dma_req, data, pin;
  logic [7:0]        word;
  int                cnt, err_count, n_tests, seed, cyc, d0, d1, s0, s1, kr, seen;
  bit                live, done, rd_q;
  logic [63:0]       rq[$], note;
  logic [7:0]        tq[$];
  assign pin = (o_data_oe & o_data) | (~o_data_oe & data);
  ssp_sync_serial_port i_dut (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_sclk(o_sclk_oe ? o_sclk : sclk), .o_sclk, .o_sclk_oe, .i_fs(o_fs_oe ? o_fs : fs),
    .o_fs, .o_fs_oe, .i_data(pin), .o_data, .o_data_oe, .o_dma_req, .i_peer_err, .o_err_irq);
  ssp_codec_model i_codec (.o_sclk(sclk), .o_fs(fs), .o_data(data), .i_data(pin),
    .o_word(word), .o_cnt(cnt));
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    if (a == REG_DATA0) tq.push_back(d[7:0]);
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    rq.push_back({m, e});
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  task automatic serve(input int c);
    repeat (c) begin
      @(negedge i_clock);
      if (live && d0 != s0) begin
        s0++;
        wr(REG_DATA0, $random(seed));
      end
      if (live && d1 != s1) begin
        s1++;
        rd(REG_DATA1, 32'h0000_00FF, {24'h0, i_codec.pat(kr)});
        kr++;
      end
    end
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (o_dma_req[0]) d0++;
    if (o_dma_req[1]) d1++;
    if (rd_q) note = rq.pop_front();
    if (rd_q) chk(o_rdata & note[63:32], note[31:0]);
    rd_q = i_rd;
    if (cnt != seen) begin
      seen = cnt;
      if (live) chk(word, tq.size() > 0 ? tq.pop_front() : 'x);
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    seed = 14071;
    {i_rst, i_addr, i_wdata, i_wr, i_rd, i_peer_err} = {1'b1, 8'h00, 32'h0, 3'h0};
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, '1, '0);
    rd(REG_MASK, '1, 32'h1);
    rd(REG_STAT, '1, '0);
    wr(REG_DATA0, $random(seed));
    wr(REG_CTRL, 32'h0000_1279);
    live = 1'b1;
    fork begin
      #7 i_codec.frames(4, 1'b0);
      done = 1'b1;
    end join_none
    while (!done) serve(1);
    serve(200);
    live = 1'b0;
    chk(o_err_irq, 1'b0);
    #7 i_codec.frames(1, 1'b1);
    repeat (10) @(negedge i_clock);
    chk(o_err_irq, 1'b1);
    rd(REG_STAT, 32'h1, 32'h1);
    @(negedge i_clock);
    chk(o_err_irq, 1'b0);
    wr(REG_MASK, '0);
    #7 i_codec.frames(1, 1'b1);
    @(negedge i_clock);
    chk(o_err_irq, 1'b0);
    rd(REG_STAT, 32'h1, 32'h1);
    i_peer_err <= 1'b1;
    @(negedge i_clock);
    chk(o_err_irq, 1'b1);
    wr(REG_CLKDIV, '0);
    i_peer_err <= 1'b0;
    wr(REG_FRAME, 32'h0000_000F);
    // Idle codec lines rest at 0 on line 0 and 1 on line 1: mu-law there, A-law here.
    wr(REG_COMPAND, 32'h0000_0009);
    wr(REG_CTRL, 32'h0000_0C79);
    repeat (200) @(posedge i_clock);
    rd(REG_DATA0, '1, 32'hFFFF_8284);
    rd(REG_DATA1, '1, 32'h0000_0350);
    repeat (2) @(posedge i_clock);
    stop_test;
  end
endmodule // tb
bind ssp_sync_serial_port ssp_checker i_chk (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .o_sclk, .o_sclk_oe, .o_fs, .o_fs_oe, .o_data_oe, .o_dma_req, .i_peer_err,
  .o_err_irq);
`default_nettype wire
